// ---- bench/cabx_exec_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module cabx_exec_tb
	import cabx_pkg::*;
;
	// Row fields: op, a, b, k, preset flags, result, flags, then {wr[1:0], tk[1:0]}
	// tk: 0 straight on, 1 branch taken, 2 skip of one word
	typedef struct packed {
		cabx_op_type op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] k;
		logic [7:0] fl;
		logic [7:0] res;
		logic [7:0] efl;
		logic [1:0] wr;
		logic [1:0] tk;
	} cabx_row_type;
	localparam int NR = 46;
	logic sys_clk, reset, issue, flags_wr, next_two_word;
	cabx_op_type op;
	logic [7:0] dst_val, src_reg, imm_val, io_val, flags_in;
	logic [15:0] pair_val, z_ptr, pc_exp;
	logic [11:0] offset;
	logic [2:0] bit_sel;
	logic ready, result_wr, word_wr;
	logic [PC_W-1:0] pc_val;
	logic [7:0] status_flags, result_val;
	logic [15:0] word_val;
	int err_count, checked;
	// Packed rows keep the table narrow; the last nibble packs write strobes and flow kind
	cabx_row_type rows [NR] = '{
		{op_add, 52'h0f0100001020_4},
		{op_add, 52'h7f010010803c_4},
		{op_add_carry, 52'hff0000010023_4},
		{op_sub, 52'h100100000f20_4},
		{op_sub_imm, 52'h00000100ff25_4},
		{op_sub_regs_carry, 52'h800000017f28_4},
		{op_sub_imm_carry, 52'h05000501ff25_4},
		{op_and, 52'hf00f00290023_4},
		{op_and_imm, 52'hc30081008104_4},
		{op_or, 52'h800100088104_4},
		{op_or_imm, 52'h000000040002_4},
		{op_xor_regs, 52'haaaa00d100d3_4},
		{op_test_zero_minus, 52'h800000008004_4},
		{op_clear_bits_mask, 52'hff000f00f004_4},
		{op_cmp_regs, 52'h010200100035_0},
		{op_cmp_regs_carry, 52'h000000010025_0},
		{op_cmp_imm, 52'h420042000002_0},
		{op_branch_eq, 52'h000000020002_1},
		{op_branch_ne, 52'h000000020002_0},
		{op_branch_unsigned_ge, 52'h000000000000_1},
		{op_branch_unsigned_lt, 52'h000000000000_0},
		{op_branch_unsigned_lt, 52'h000000010001_1},
		{op_branch_carry_set, 52'h000000010001_1},
		{op_branch_carry_clear, 52'h000000010001_0},
		{op_nop, 52'h000000ff00ff_0},
		{op_branch_minus, 52'h000000040004_1},
		{op_branch_plus, 52'h000000040004_0},
		{op_branch_signed_ge, 52'h0000000c000c_1},
		{op_branch_signed_lt, 52'h0000000c000c_0},
		{op_branch_signed_lt, 52'h000000080008_1},
		{op_branch_halfcarry_set, 52'h000000200020_1},
		{op_branch_halfcarry_clear, 52'h000000200020_0},
		{op_branch_tbit_set, 52'h000000400040_1},
		{op_branch_tbit_clear, 52'h000000400040_0},
		{op_branch_ovf_set, 52'h000000080008_1},
		{op_branch_ovf_clear, 52'h000000080008_0},
		{op_branch_int_enabled, 52'h000000800080_1},
		{op_branch_int_enabled, 52'h0000007f007f_0},
		{op_branch_flag_set, 52'h000005200020_1},
		{op_branch_flag_clear, 52'h000006200020_1},
		{op_cmp_skip_equal, 52'h050500000000_2},
		{op_cmp_skip_equal, 52'h050600000000_0},
		{op_skip_reg_bit_clear, 52'h00f703000000_2},
		{op_skip_reg_bit_set, 52'h00f703000000_0},
		{op_skip_io_bit_set, 52'h000803000000_2},
		{op_skip_io_bit_clear, 52'h000803000000_0}
	};

	cabx_exec i_dut (.sys_clk(sys_clk), .reset(reset), .issue(issue), .ready(ready), .op(op),
		.dst_val(dst_val), .src_reg(src_reg), .imm_val(imm_val), .pair_val(pair_val),
		.z_ptr(z_ptr), .offset(offset), .bit_sel(bit_sel), .io_val(io_val),
		.next_two_word(next_two_word), .flags_wr(flags_wr), .flags_in(flags_in),
		.pc_val(pc_val), .status_flags(status_flags), .result_val(result_val),
		.result_wr(result_wr), .word_val(word_val), .word_wr(word_wr));

	// Free-running core clock, 100 ns period
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task summarize();
		if (err_count == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Preload flags through the idle load path; costs one cycle, pc untouched
	task setf(input logic [7:0] f);
		issue = 1'b0;
		flags_wr = 1'b1;
		flags_in = f;
		@(posedge sys_clk) #10;
		flags_wr = 1'b0;
	endtask

	// Issue is left high on return from a single-cycle op so such ops can follow back to back
	task exec(input cabx_op_type o, input logic [7:0] a, b, k, input logic [15:0] epc,
		input logic [1:0] ewr, input logic [7:0] eres, efl, input int ec);
		int cyc;
		dst_val = a;
		src_reg = b;
		io_val = b;
		imm_val = k;
		bit_sel = k[2:0];
		op = o;
		issue = 1'b1;
		@(posedge sys_clk) #10;
		chk(pc_val, epc);
		pc_exp = epc;
		chk(status_flags, efl);
		chk(result_wr, ewr[0]);
		chk(word_wr, ewr[1]);
		if (ewr[0]) chk(result_val, eres);
		cyc = 1;
		while (ready !== 1'b1 && cyc < 6) begin
			issue = 1'b0;
			@(posedge sys_clk) #10;
			cyc++;
		end
		chk(16'(cyc), 16'(ec));
	endtask

	task wop(input cabx_op_type o, input logic [15:0] p, input logic [7:0] k, f,
		input logic [15:0] ew, input logic [7:0] ef);
		setf(f);
		pair_val = p;
		exec(o, 8'h00, 8'h00, k, pc_exp + 16'h0001, 2'h2, 8'h00, ef, 2);
		chk(word_val, ew);
	endtask

	// Main sequence: reset, table, then the awkward cases
	initial begin
		reset = 1'b1;
		issue = 1'b0;
		flags_wr = 1'b0;
		next_two_word = 1'b0;
		op = op_nop;
		{dst_val, src_reg, imm_val, io_val, flags_in} = 40'h00_0000_0000;
		{pair_val, z_ptr} = 32'h0000_0000;
		offset = 12'h010;
		bit_sel = 3'h0;
		pc_exp = 16'h0000;
		err_count = 0;
		checked = 0;
		repeat (12) @(posedge sys_clk);
		#10;
		chk(pc_val, 16'h0000);
		chk(status_flags, 8'h00);
		chk(result_val, 8'h00);
		chk(word_val, 16'h0000);
		chk(ready, 1'b1);
		reset = 1'b0;
		for (int i = 0; i < NR; i++) begin
			setf(rows[i].fl);
			exec(rows[i].op, rows[i].a, rows[i].b, rows[i].k,
				pc_exp + (rows[i].tk == 2'h1 ? 16'h0011 :
				{14'h0000, rows[i].tk == 2'h2, rows[i].tk != 2'h2}),
				rows[i].wr, rows[i].res, rows[i].efl, rows[i].tk == 2'h0 ? 1 : 2);
		end
		// Word arithmetic: carry, zero, sign and overflow out of bit 15
		wop(op_add_imm_word, 16'h7fff, 8'h01, 8'h00, 16'h8000, 8'h0c);
		wop(op_add_imm_word, 16'hffff, 8'h01, 8'h20, 16'h0000, 8'h23);
		wop(op_sub_imm_word, 16'h0000, 8'h01, 8'h00, 16'hffff, 8'h15);
		wop(op_sub_imm_word, 16'h8000, 8'h01, 8'h00, 16'h7fff, 8'h18);
		// Skip over a two-word instruction
		next_two_word = 1'b1;
		setf(8'h00);
		exec(op_skip_reg_bit_set, 8'h00, 8'h01, 8'h00, pc_exp + 16'h0003, 2'h0, 8'h00, 8'h00,
			2);
		next_two_word = 1'b0;
		// Backward call, then a jump and a flag load offered while busy must be ignored
		setf(8'h5a);
		offset = 12'hff0;
		op = op_rel_call;
		issue = 1'b1;
		@(posedge sys_clk) #10;
		pc_exp = pc_exp + 16'hfff1;
		chk(pc_val, pc_exp);
		op = op_ind_jump;
		z_ptr = 16'h0abc;
		flags_wr = 1'b1;
		flags_in = 8'hff;
		@(posedge sys_clk) #10;
		chk(pc_val, pc_exp);
		chk(status_flags, 8'h5a);
		chk(ready, 1'b0);
		issue = 1'b0;
		flags_wr = 1'b0;
		@(posedge sys_clk) #10;
		chk(ready, 1'b1);
		z_ptr = 16'h1234;
		exec(op_ind_call, 8'h00, 8'h00, 8'h00, 16'h1234, 2'h0, 8'h00, 8'h5a, 3);
		z_ptr = 16'h0abc;
		exec(op_ind_jump, 8'h00, 8'h00, 8'h00, 16'h0abc, 2'h0, 8'h00, 8'h5a, 2);
		// Single-cycle ops taken on consecutive edges
		setf(8'h00);
		exec(op_add, 8'h01, 8'h01, 8'h00, pc_exp + 16'h0001, 2'h1, 8'h02, 8'h00, 1);
		exec(op_sub, 8'h02, 8'h02, 8'h00, pc_exp + 16'h0001, 2'h1, 8'h00, 8'h02, 1);
		issue = 1'b0;
		// Reset in mid-run clears state without a clock edge
		reset = 1'b1;
		#10;
		chk(pc_val, 16'h0000);
		chk(status_flags, 8'h00);
		chk(result_val, 8'h00);
		chk(word_val, 16'h0000);
		chk(ready, 1'b1);
		@(posedge sys_clk) #10;
		reset = 1'b0;
		exec(op_add, 8'h01, 8'h02, 8'h00, 16'h0001, 2'h1, 8'h03, 8'h00, 1);
		issue = 1'b0;
		summarize();
	end

	// Watchdog: the whole sequence needs well under 600 cycles
	initial begin
		#200000;
		err_count++;
		summarize();
	end
endmodule
`default_nettype wire

// ---- rtl/cabx_exec.sv ----
// Functional notes
// RULE_01: Add registers, optional carry, flags ZCNVH, 1 cycle
// RULE_02: Add constant to word pair, ZCNVS, 2 cycles
// RULE_03: Subtract constant from word pair, ZCNVS, 2 cycles
// RULE_04: Subtract register/constant, optional carry, ZCNVH, 1 cycle
// RULE_05: AND/OR/XOR store result, flags ZNV only
// RULE_06: Test register ANDs itself, sets ZNV
// RULE_07: Clear bits ANDs complement mask, ZNV
// RULE_08: Relative call: PC+k+1, no flags, 3 cycles
// RULE_09: Indirect call: PC from Z, 3 cycles
// RULE_10: Indirect jump: PC from Z, 2 cycles
// RULE_11: Skip if equal: PC+2 or 3, 1/2 cycles
// RULE_12: Compares set flags, store no result
// RULE_13: Skip on register bit clear or set
// RULE_14: Skip on I/O bit clear or set
// RULE_15: Generic flag branch, PC+k+1, 1/2 cycles
// RULE_16: Signed branches test N xor V
// RULE_17: Unsigned branches test carry flag
// RULE_18: Equal/not-equal test Z, minus/plus test N
// RULE_19: Half-carry branches test H
// RULE_20: T branches test transfer bit
// RULE_21: Overflow branches test V, 1/2 cycles
// RULE_22: Interrupt-enabled branch tests I
// RULE_23: Unlisted flags keep their value
`timescale 1ns/100ps
`default_nettype none
module cabx_exec
	import cabx_pkg::*;
(
	input wire logic sys_clk, // Core clock, 10 MHz
	input wire logic reset, // Asynchronous, active high
	input wire logic issue, // Instruction offered this cycle
	output logic ready, // Core can take an instruction
	input wire cabx_op_type op, // Decoded operation
	input wire logic [7:0] dst_val, // Destination register value
	input wire logic [7:0] src_reg, // Source register value
	input wire logic [7:0] imm_val, // Constant operand
	input wire logic [15:0] pair_val, // High:low register pair
	input wire logic [15:0] z_ptr, // Z pointer register
	input wire logic [11:0] offset, // Signed relative offset k
	input wire logic [2:0] bit_sel, // Bit or flag number
	input wire logic [7:0] io_val, // Addressed I/O register value
	input wire logic next_two_word, // Following instruction is two words
	input wire logic flags_wr, // Load status_flags from flags_in while ready and issue is low
	input wire logic [7:0] flags_in, // Value for flags_wr
	output logic [PC_W-1:0] pc_val, // Program counter
	output logic [7:0] status_flags, // I T H S V N Z C
	output logic [7:0] result_val, // Byte result
	output logic result_wr, // Byte result write pulse
	output logic [15:0] word_val, // Word result
	output logic word_wr // Word result write pulse
);

	cabx_regs_type q, d;
	logic acc;
	logic [7:0] opb;
	logic cin;
	logic [8:0] sum9, diff9;
	logic add_h, add_v, sub_h, sub_v;
	logic [15:0] wsum, wdiff;
	logic [PC_W-1:0] seq_pc, rel_pc, skip_pc;
	logic skip_hit, br_hit;
	logic [1:0] cyc;

	// Byte arithmetic flag update; S, T, I untouched
	function automatic logic [7:0] fl_arith(input logic [7:0] f, input logic [7:0] r,
		input logic c, input logic v, input logic h);
		logic [7:0] n;
		n = f;
		n[FLG_Z] = (r == 8'h00);
		n[FLG_C] = c;
		n[FLG_N] = r[7];
		n[FLG_V] = v;
		n[FLG_H] = h;
		return n;
	endfunction

	// Logic flag update; carry and half-carry survive
	function automatic logic [7:0] fl_logic(input logic [7:0] f, input logic [7:0] r);
		logic [7:0] n;
		n = f;
		n[FLG_Z] = (r == 8'h00); // RULE_05
		n[FLG_N] = r[7];
		n[FLG_V] = 1'b0;
		return n;
	endfunction

	// Word flag update; H keeps its value, S follows N xor V
	function automatic logic [7:0] fl_word(input logic [7:0] f, input logic [15:0] r,
		input logic c, input logic v);
		logic [7:0] n;
		n = f;
		n[FLG_Z] = (r == 16'h0000);
		n[FLG_C] = c;
		n[FLG_N] = r[15];
		n[FLG_V] = v;
		n[FLG_S] = r[15] ^ v;
		return n;
	endfunction

	// Branch conditions on the current flags
	function automatic logic br_cond(input cabx_op_type o, input logic [7:0] f,
		input logic [2:0] s);
		case (o)
			op_branch_flag_set: br_cond = f[s]; // RULE_15
			op_branch_flag_clear: br_cond = ~f[s]; // RULE_15
			op_branch_eq: br_cond = f[FLG_Z]; // RULE_18
			op_branch_ne: br_cond = ~f[FLG_Z]; // RULE_18
			op_branch_carry_set, op_branch_unsigned_lt: br_cond = f[FLG_C]; // RULE_17
			op_branch_carry_clear, op_branch_unsigned_ge: br_cond = ~f[FLG_C]; // RULE_17
			op_branch_minus: br_cond = f[FLG_N]; // RULE_18
			op_branch_plus: br_cond = ~f[FLG_N]; // RULE_18
			op_branch_signed_ge: br_cond = ~(f[FLG_N] ^ f[FLG_V]); // RULE_16
			op_branch_signed_lt: br_cond = f[FLG_N] ^ f[FLG_V]; // RULE_16
			op_branch_halfcarry_set: br_cond = f[FLG_H]; // RULE_19
			op_branch_halfcarry_clear: br_cond = ~f[FLG_H]; // RULE_19
			op_branch_tbit_set: br_cond = f[FLG_T]; // RULE_20
			op_branch_tbit_clear: br_cond = ~f[FLG_T]; // RULE_20
			op_branch_ovf_set: br_cond = f[FLG_V]; // RULE_21
			op_branch_ovf_clear: br_cond = ~f[FLG_V]; // RULE_21
			op_branch_int_enabled: br_cond = f[FLG_I]; // RULE_22
			default: br_cond = 1'b0;
		endcase
	endfunction

	// Second operand: register, constant, inverted mask or the operand itself
	always_comb begin
		case (op)
			op_sub_imm, op_sub_imm_carry, op_and_imm, op_or_imm, op_cmp_imm: opb = imm_val;
			op_clear_bits_mask: opb = ~imm_val; // RULE_07
			op_test_zero_minus: opb = dst_val; // RULE_06
			default: opb = src_reg;
		endcase
	end

	// Carry enters only the with-carry forms
	assign cin = q.flags[FLG_C] & ((op == op_add_carry) | (op == op_sub_regs_carry) |
		(op == op_sub_imm_carry) | (op == op_cmp_regs_carry)); // RULE_01

	// One adder and one subtractor serve every byte add, subtract and compare form
	assign sum9 = {1'b0, dst_val} + {1'b0, opb} + {8'h00, cin};
	assign diff9 = {1'b0, dst_val} - {1'b0, opb} - {8'h00, cin};
	assign add_h = (dst_val[3] & opb[3]) | (opb[3] & ~sum9[3]) | (~sum9[3] & dst_val[3]);
	assign add_v = (dst_val[7] & opb[7] & ~sum9[7]) | (~dst_val[7] & ~opb[7] & sum9[7]);
	assign sub_h = (~dst_val[3] & opb[3]) | (opb[3] & diff9[3]) | (diff9[3] & ~dst_val[3]);
	assign sub_v = (dst_val[7] & ~opb[7] & ~diff9[7]) | (~dst_val[7] & opb[7] & diff9[7]);

	// Word forms; the constant is zero-extended
	assign wsum = pair_val + {8'h00, imm_val}; // RULE_02
	assign wdiff = pair_val - {8'h00, imm_val}; // RULE_03

	// Program counter candidates
	assign seq_pc = q.pc + PC_ONE;
	assign rel_pc = q.pc + PC_W'(signed'(offset)) + PC_ONE; // RULE_08
	assign skip_pc = q.pc + PC_W'(next_two_word ? SKIP_TWO_WORD : SKIP_ONE_WORD); // RULE_11

	// Skip conditions
	always_comb begin
		case (op)
			op_cmp_skip_equal: skip_hit = (dst_val == src_reg); // RULE_11
			op_skip_reg_bit_clear: skip_hit = ~src_reg[bit_sel]; // RULE_13
			op_skip_reg_bit_set: skip_hit = src_reg[bit_sel]; // RULE_13
			op_skip_io_bit_clear: skip_hit = ~io_val[bit_sel]; // RULE_14
			op_skip_io_bit_set: skip_hit = io_val[bit_sel]; // RULE_14
			default: skip_hit = 1'b0;
		endcase
	end

	assign br_hit = br_cond(op, q.flags, bit_sel);
	assign ready = (q.state == ST_IDLE);
	assign acc = issue & ready;

	// Everything commits at the accepting edge; the wait state only stalls issue and flag loads.
	// This keeps results visible early at the cost of modelling no pipeline hazards.
	always_comb begin
		d = q;
		d.res_wr = 1'b0;
		d.word_wr = 1'b0;
		cyc = CYC_ONE;
		unique case (q.state)
			ST_WAIT: begin
				d.cnt = q.cnt - 2'h1;
				if (q.cnt == 2'h1) begin
					d.state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (issue) begin
					d.pc = seq_pc;
					case (op)
						op_add, op_add_carry: begin
							d.res = sum9[7:0]; // RULE_01
							d.res_wr = 1'b1;
							d.flags = fl_arith(q.flags, sum9[7:0], sum9[8], add_v, add_h);
						end
						op_sub, op_sub_imm, op_sub_regs_carry, op_sub_imm_carry: begin
							d.res = diff9[7:0]; // RULE_04
							d.res_wr = 1'b1;
							d.flags = fl_arith(q.flags, diff9[7:0], diff9[8], sub_v, sub_h);
						end
						op_cmp_regs, op_cmp_regs_carry, op_cmp_imm: begin
							d.flags = fl_arith(q.flags, diff9[7:0], diff9[8], sub_v, sub_h); // RULE_12
						end
						op_and, op_and_imm, op_test_zero_minus, op_clear_bits_mask: begin
							d.res = dst_val & opb; // RULE_05
							d.res_wr = 1'b1;
							d.flags = fl_logic(q.flags, dst_val & opb); // RULE_06
						end
						op_or, op_or_imm: begin
							d.res = dst_val | opb; // RULE_05
							d.res_wr = 1'b1;
							d.flags = fl_logic(q.flags, dst_val | opb);
						end
						op_xor_regs: begin
							d.res = dst_val ^ opb; // RULE_05
							d.res_wr = 1'b1;
							d.flags = fl_logic(q.flags, dst_val ^ opb);
						end
						op_add_imm_word: begin
							d.word = wsum;
							d.word_wr = 1'b1;
							d.flags = fl_word(q.flags, wsum, pair_val[15] & ~wsum[15],
								~pair_val[15] & wsum[15]); // RULE_02
							cyc = CYC_TWO;
						end
						op_sub_imm_word: begin
							d.word = wdiff;
							d.word_wr = 1'b1;
							d.flags = fl_word(q.flags, wdiff, wdiff[15] & ~pair_val[15],
								pair_val[15] & ~wdiff[15]); // RULE_03
							cyc = CYC_TWO;
						end
						op_rel_call: begin
							d.pc = rel_pc; // RULE_08
							cyc = CYC_THREE;
						end
						op_ind_call: begin
							d.pc = z_ptr; // RULE_09
							cyc = CYC_THREE;
						end
						op_ind_jump: begin
							d.pc = z_ptr; // RULE_10
							cyc = CYC_TWO;
						end
						op_cmp_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set,
						op_skip_io_bit_clear, op_skip_io_bit_set: begin
							if (skip_hit) begin
								d.pc = skip_pc; // RULE_13
								cyc = CYC_TWO; // RULE_11
							end
						end
						default: begin
							if (br_hit) begin
								d.pc = rel_pc; // RULE_15
								cyc = CYC_TWO; // RULE_21
							end
						end
					endcase
					if (cyc != CYC_ONE) begin
						d.state = ST_WAIT;
						d.cnt = cyc - 2'h1;
					end
				end else if (flags_wr) begin
					d.flags = flags_in;
				end
			end
			default: d.state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			q <= '{state: ST_IDLE, cnt: 2'h0, pc: PC_RST, flags: FLAGS_RST, res: RES_RST,
				res_wr: 1'b0, word: WORD_RST, word_wr: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign pc_val = q.pc;
	assign status_flags = q.flags;
	assign result_val = q.res;
	assign result_wr = q.res_wr;
	assign word_val = q.word;
	assign word_wr = q.word_wr;
	// Checks on committed behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_add_result; // RULE_01
		acc && op == op_add |=> result_wr && result_val == 8'($past(dst_val) + $past(src_reg))
			&& ready;
	endproperty
	a_add_result: assert property (p_add_result) else $error("add result or timing wrong"); // RULE_01
	property p_word_add_time; // RULE_02
		acc && op == op_add_imm_word |=> word_wr && !ready ##1 ready;
	endproperty
	a_word_add_time: assert property (p_word_add_time) else $error("word add timing"); // RULE_02
	property p_word_sub; // RULE_03
		acc && op == op_sub_imm_word |=>
			word_val == 16'($past(pair_val) - {8'h00, $past(imm_val)})
			&& status_flags[FLG_H] == $past(status_flags[FLG_H]);
	endproperty
	a_word_sub: assert property (p_word_sub) else $error("word subtract wrong"); // RULE_03
	property p_sub_borrow; // RULE_04
		acc && op == op_sub |=> status_flags[FLG_C] == ($past(src_reg) > $past(dst_val));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("subtract borrow wrong"); // RULE_04
	property p_logic_flags; // RULE_05
		acc && (op == op_and || op == op_or || op == op_xor_regs) |=> !status_flags[FLG_V]
			&& status_flags[FLG_C] == $past(status_flags[FLG_C]);
	endproperty
	a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong"); // RULE_05
	property p_call_time; // RULE_08
		acc && op == op_rel_call |=> pc_val == 16'($past(q.pc) + 16'(signed'($past(offset)))
			+ PC_ONE) && !ready ##1 !ready ##1 ready;
	endproperty
	a_call_time: assert property (p_call_time) else $error("relative call wrong"); // RULE_08
	property p_ind_jump; // RULE_10
		acc && op == op_ind_jump |=> pc_val == $past(z_ptr) && !ready ##1 ready;
	endproperty
	a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong"); // RULE_10
	property p_cmp_no_store; // RULE_12
		acc && (op == op_cmp_regs || op == op_cmp_imm) |=> !result_wr && $stable(result_val);
	endproperty
	a_cmp_no_store: assert property (p_cmp_no_store) else $error("compare stored result"); // RULE_12
	property p_signed_ge; // RULE_16
		acc && op == op_branch_signed_ge && !(q.flags[FLG_N] ^ q.flags[FLG_V]) |=>
			pc_val == 16'($past(q.pc) + 16'(signed'($past(offset))) + PC_ONE) ##1 ready;
	endproperty
	a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong"); // RULE_16
	property p_branch_keeps_flags; // RULE_23
		acc && op >= op_branch_flag_set |=> status_flags == $past(status_flags);
	endproperty
	a_branch_keeps_flags: assert property (p_branch_keeps_flags) // RULE_23
		else $error("branch altered flags");
endmodule
`default_nettype wire

// ---- rtl/cabx_pkg.sv ----
package cabx_pkg;
	// Program counter width and reset values
	localparam int PC_W = 16;
	localparam logic [PC_W-1:0] PC_RST = 16'h0000;
	localparam logic [PC_W-1:0] PC_ONE = 16'h0001;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] RES_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;

	// Bit positions inside status_flags
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 3;
	localparam int FLG_S = 4;
	localparam int FLG_H = 5;
	localparam int FLG_T = 6;
	localparam int FLG_I = 7;

	// Cycle counts and skip distances
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [1:0] SKIP_ONE_WORD = 2'h2;
	localparam logic [1:0] SKIP_TWO_WORD = 2'h3;

	typedef enum logic [5:0] {
		op_nop, op_add, op_add_carry, op_add_imm_word, op_sub, op_sub_imm,
		op_sub_imm_word, op_sub_regs_carry, op_sub_imm_carry, op_and, op_and_imm,
		op_or, op_or_imm, op_xor_regs, op_test_zero_minus, op_clear_bits_mask,
		op_rel_call, op_ind_call, op_ind_jump, op_cmp_skip_equal, op_cmp_regs,
		op_cmp_regs_carry, op_cmp_imm, op_skip_reg_bit_clear, op_skip_reg_bit_set,
		op_skip_io_bit_clear, op_skip_io_bit_set, op_branch_flag_set,
		op_branch_flag_clear, op_branch_eq, op_branch_ne, op_branch_carry_set,
		op_branch_carry_clear, op_branch_unsigned_ge, op_branch_unsigned_lt,
		op_branch_minus, op_branch_plus, op_branch_signed_ge, op_branch_signed_lt,
		op_branch_halfcarry_set, op_branch_halfcarry_clear, op_branch_tbit_set,
		op_branch_tbit_clear, op_branch_ovf_set, op_branch_ovf_clear,
		op_branch_int_enabled
	} cabx_op_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} cabx_state_type;

	typedef struct packed {
		cabx_state_type state;
		logic [1:0] cnt;
		logic [PC_W-1:0] pc;
		logic [7:0] flags;
		logic [7:0] res;
		logic res_wr;
		logic [15:0] word;
		logic word_wr;
	} cabx_regs_type;
endpackage
